// [hdl/power_sample_sequencer_regs.vh]
// Register map, fields and constants of the power sample sequencer
`ifndef POWER_SAMPLE_SEQUENCER_REGS_VH
`define POWER_SAMPLE_SEQUENCER_REGS_VH
// Register byte offsets
`define OFS_CTRL     8'h00
`define OFS_TRIG     8'h04
`define OFS_AVG      8'h08
`define OFS_SAMPLES  8'h0c
`define OFS_LOOPS    8'h10
`define OFS_PERIOD   8'h14
`define OFS_WINDOW   8'h18
`define OFS_STATUS   8'h1c
`define OFS_READING  8'h20
`define OFS_MIN      8'h24
`define OFS_MAX      8'h28
`define OFS_INDEX    8'h2c
`define OFS_BUF_ADDR 8'h30
`define OFS_BUF_DATA 8'h34
// Control register fields
`define CTRL_FUNC_HI   1
`define CTRL_FUNC_LO   0
`define CTRL_START     2
`define CTRL_STOP      3
`define CTRL_EXT_EN    4
`define CTRL_EXT_REFR  5
`define CTRL_TRIG_LOW  6
`define CTRL_LOOP_EACH 7
// Trigger register fields
`define TRIG_GLOB_HI 1
`define TRIG_GLOB_LO 0
`define TRIG_IN_HI   3
`define TRIG_IN_LO   2
`define TRIG_OUT_HI  5
`define TRIG_OUT_LO  4
// Measurement functions
`define FUNC_LIVE 2'h0
`define FUNC_LOG  2'h1
`define FUNC_STAB 2'h2
// Global trigger modes
`define GLOB_OFF 2'h0
`define GLOB_ON  2'h1
`define GLOB_FWD 2'h2
// Input trigger functions
`define TIN_IGNORE 2'h0
`define TIN_SINGLE 2'h1
`define TIN_FULL   2'h2
// Output trigger sources
`define TOUT_NONE  2'h0
`define TOUT_BEGIN 2'h1
`define TOUT_DONE  2'h2
// Reset values
`define RST_AVG     32'h00000001
`define RST_SAMPLES 32'h00000001
`define RST_LOOPS   32'h00000001
`define RST_PERIOD  32'h00000001
`define RST_WINDOW  32'h00000001
// Widths and sizes
`define PW     16
`define BUF_AW 20
`define MEM_AW 21
`define BUF_BIT 20
// Longest stability run in hours, reached with 32-bit counts
`define STAB_MAX_HOURS 277
`endif

// [hdl/power_sample_sequencer.v]
// Measurement sequencer: extreme tracking, triggers, logging, stability
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "power_sample_sequencer_regs.vh"

// Notes on behaviour
// - Report min, max; delta replaces reading
// - Continuous: update extremes, never auto clear
// - Refresh: clear extremes after window count
// - Trigger input active high, rising edge
// - Global trigger: off, on, or forward
// - Per port: ignore, single, or full function
// - Output trigger: none, begin, inverted done
// - Logging samples run back to back
// - Logging run lasts samples times interval
// - Range held fixed during logging
// - Shared parameters loaded before logging starts
// - Two 1M buffers, one readable while filling
// - One loop writes only buffer A
// - Zero loops alternate buffers until stopped
// - n loops alternate A, B until done
// - Triggers start each loop or whole series
// - Progress index updated after each loop
// - New stability measurement every period
// - Dwell for rest of period, none if equal
// - Stability run ends after final dwell
// - Stability runs reach 277 hours
module power_sample_sequencer
(
	input  wire            sys_clk,
	input  wire            resetn,
	input  wire [7:0]      addr,
	input  wire [31:0]     wr_data,
	input  wire            wr_en,
	input  wire            rd_en,
	output reg  [31:0]     rd_data,
	input  wire [`PW-1:0]  power_in,
	input  wire            trig_in,
	output reg             trig_out,
	output reg             meas_begin,
	output reg             range_hold
);

	//--------------------------------------------------------------
	// States and declarations
	//--------------------------------------------------------------
	localparam [1:0] S_IDLE  = 2'h0;  // Nothing running
	localparam [1:0] S_WAIT  = 2'h1;  // Armed, waiting for trigger
	localparam [1:0] S_AVG   = 2'h2;  // Averaging interval
	localparam [1:0] S_DWELL = 2'h3;  // Idle rest of period

	reg  [7:0]         ctrl_q;        // Control bits
	reg  [5:0]         trig_cfg_q;    // Trigger configuration
	reg  [31:0]        avg_len_q;     // Averaging interval, cycles
	reg  [31:0]        samples_q;     // Samples per run
	reg  [31:0]        loops_q;       // Repeat count
	reg  [31:0]        period_q;      // Stability period, cycles
	reg  [31:0]        window_q;      // Refresh window length
	reg  [`MEM_AW-1:0] buf_addr_q;    // Readout address
	reg  [1:0]         state_q;       // Sequencer state
	reg  [31:0]        avg_cnt_q;     // Cycles into interval
	reg  [31:0]        per_cnt_q;     // Cycles into period
	reg  [31:0]        smp_cnt_q;     // Samples this run, 32 bits
	reg  [31:0]        loop_cnt_q;    // Runs finished
	reg  [31:0]        index_q;       // Progress index
	reg                buf_sel_q;     // Buffer being filled
	reg                single_q;      // One-shot measurement
	reg                live_q;        // Free-running live readings
	reg  [`PW-1:0]     last_q;        // Latest sample
	reg  [`PW-1:0]     min_q;         // Stored minimum
	reg  [`PW-1:0]     max_q;         // Stored maximum
	reg                first_q;       // Next sample loads extremes
	reg  [31:0]        win_cnt_q;     // Samples in window
	reg                sync1_q;       // Synchroniser stage one
	reg                sync2_q;       // Synchroniser stage two
	reg                trig_prev_q;   // Previous synced level
	reg  [`PW-1:0]     buf_mem [0:(1<<`MEM_AW)-1]; // Buffers A and B

	wire [1:0] func     = ctrl_q[`CTRL_FUNC_HI:`CTRL_FUNC_LO];
	wire [1:0] glob     = trig_cfg_q[`TRIG_GLOB_HI:`TRIG_GLOB_LO];
	wire [1:0] tin      = trig_cfg_q[`TRIG_IN_HI:`TRIG_IN_LO];
	wire [1:0] tout     = trig_cfg_q[`TRIG_OUT_HI:`TRIG_OUT_LO];
	wire       wr_ctrl  = wr_en && (addr == `OFS_CTRL);
	wire       start_cmd = wr_ctrl && wr_data[`CTRL_START];
	wire       stop_cmd  = wr_ctrl && wr_data[`CTRL_STOP];
	wire       busy     = (state_q != S_IDLE);

	//--------------------------------------------------------------
	// Helper functions
	//--------------------------------------------------------------
	// Last cycle of a count of the given length (zero acts as one)
	function is_last;
		input [31:0] cnt;
		input [31:0] len;
		begin
			is_last = (len == 32'h0) ? 1'b1 : (cnt == len - 32'h1);
		end
	endfunction

	// Function codes that run a sequence rather than live readings
	function is_seq;
		input [1:0] fn;
		begin
			is_seq = (fn == `FUNC_LOG) || (fn == `FUNC_STAB);
		end
	endfunction

	//--------------------------------------------------------------
	// Trigger input
	//--------------------------------------------------------------
	// Two-stage synchroniser, then edge detect on the second stage
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sync1_q     <= 1'b0;
			sync2_q     <= 1'b0;
			trig_prev_q <= 1'b0;
		end
		else
		begin
			sync1_q     <= trig_in;
			sync2_q     <= sync1_q;
			trig_prev_q <= sync2_q;
		end
	end

	// Active high by default; polarity bit selects falling edge
	wire trig_edge = ctrl_q[`CTRL_TRIG_LOW] ?
		(trig_prev_q && !sync2_q) : (!trig_prev_q && sync2_q);
	// Accepted only when triggering is not disabled
	wire trig_acc = trig_edge && (glob != `GLOB_OFF);
	wire trig_full = trig_acc && (tin == `TIN_FULL);
	wire trig_one  = trig_acc && (tin == `TIN_SINGLE);

	//--------------------------------------------------------------
	// Sequencing conditions
	//--------------------------------------------------------------
	wire avg_end  = (state_q == S_AVG) && is_last(avg_cnt_q, avg_len_q);
	wire per_end  = is_last(per_cnt_q, period_q);
	wire run_fn   = is_seq(func);
	// Start takes the function written beside it, not the old one
	wire start_fn = is_seq(wr_data[`CTRL_FUNC_HI:`CTRL_FUNC_LO]);
	// Start arms and waits when a trigger is to start it
	wire start_arm = (tin == `TIN_FULL) && (glob != `GLOB_OFF) &&
		(start_fn || wr_data[`CTRL_LOOP_EACH]);
	wire logging  = run_fn && (func == `FUNC_LOG) && !single_q;
	wire stab     = (func == `FUNC_STAB) && !single_q;
	wire run_last = is_last(smp_cnt_q, samples_q);
	// Zero loops never ends on its own
	wire loop_last = (loops_q != 32'h0) && is_last(loop_cnt_q, loops_q);
	// Each loop waits for its own trigger when so configured
	wire loop_wait = ctrl_q[`CTRL_LOOP_EACH] && (tin == `TIN_FULL) &&
		(glob != `GLOB_OFF);
	wire do_store  = avg_end && (logging || stab);
	wire begin_ev  = (state_q != S_AVG || avg_end) && (
		(state_q == S_IDLE && (trig_one || (start_cmd && !start_arm))) ||
		(state_q == S_WAIT && trig_full) ||
		(state_q == S_DWELL && per_end && !(smp_cnt_q == samples_q)) ||
		(avg_end && ((live_q && !single_q) ||
			(logging && !(run_last && (loop_last || loop_wait))) ||
			(stab && per_end && !run_last))));

	//--------------------------------------------------------------
	// Sequencer
	//--------------------------------------------------------------
	// Runs live, single, logging and stability timing
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q    <= S_IDLE;
			avg_cnt_q  <= 32'h0;
			per_cnt_q  <= 32'h0;
			smp_cnt_q  <= 32'h0;
			loop_cnt_q <= 32'h0;
			index_q    <= 32'h0;
			buf_sel_q  <= 1'b0;
			single_q   <= 1'b0;
			live_q     <= 1'b0;
		end
		else if (stop_cmd)
		begin
			state_q  <= S_IDLE;
			single_q <= 1'b0;
			live_q   <= 1'b0;
		end
		else if (begin_ev)
		begin
			// Every measurement starts a fresh interval and period
			state_q   <= S_AVG;
			avg_cnt_q <= 32'h0;
			per_cnt_q <= 32'h0;
			if (state_q == S_IDLE)
			begin
				single_q  <= trig_one;
				live_q    <= !trig_one && !start_fn;
				smp_cnt_q <= 32'h0;
				loop_cnt_q <= 32'h0;
				index_q   <= 32'h0;
				buf_sel_q <= 1'b0;
			end
			else if (do_store && run_last && logging)
			begin
				// Next loop follows at once into the other buffer
				smp_cnt_q  <= 32'h0;
				loop_cnt_q <= loop_cnt_q + 32'h1;
				index_q    <= index_q + 32'h1;
				buf_sel_q  <= !buf_sel_q;
			end
			else if (do_store)
				// Back to back: next interval begins with no gap
				smp_cnt_q <= smp_cnt_q + 32'h1;
		end
		else if (state_q == S_IDLE && start_cmd)
		begin
			// Armed; the whole series or first loop waits
			state_q    <= S_WAIT;
			live_q     <= !start_fn;
			smp_cnt_q  <= 32'h0;
			loop_cnt_q <= 32'h0;
			index_q    <= 32'h0;
			buf_sel_q  <= 1'b0;
		end
		else if (state_q == S_AVG)
		begin
			avg_cnt_q <= avg_cnt_q + 32'h1;
			per_cnt_q <= per_cnt_q + 32'h1;
			if (avg_end)
			begin
				single_q <= 1'b0;
				if (do_store)
					smp_cnt_q <= run_last && logging ?
						32'h0 : smp_cnt_q + 32'h1;
				if (logging && run_last)
				begin
					// Run lasted samples times interval
					loop_cnt_q <= loop_cnt_q + 32'h1;
					index_q    <= index_q + 32'h1;
					// One loop keeps buffer A only
					if (loops_q != 32'h1)
						buf_sel_q <= !buf_sel_q;
					state_q <= loop_last ? S_IDLE : S_WAIT;
				end
				else if (stab && per_end)
				begin
					// Period used up: no dwell, the run ends
					state_q <= S_IDLE;
					index_q <= index_q + 32'h1;
				end
				else if (stab)
					// Rest of period is dwell; last one too
					state_q <= S_DWELL;
				else
					state_q <= S_IDLE;
			end
		end
		else if (state_q == S_DWELL)
		begin
			per_cnt_q <= per_cnt_q + 32'h1;
			// Run ends only when the final dwell expires
			if (per_end)
			begin
				state_q <= S_IDLE;
				index_q <= index_q + 32'h1;
			end
		end
	end

	//--------------------------------------------------------------
	// Result buffers
	//--------------------------------------------------------------
	// Fill one buffer while software reads either one
	always @(posedge sys_clk)
	begin
		if (do_store)
			buf_mem[{buf_sel_q, smp_cnt_q[`BUF_AW-1:0]}] <= power_in;
	end

	//--------------------------------------------------------------
	// Extreme tracking
	//--------------------------------------------------------------
	wire [31:0] win_next = first_q ? 32'h1 : win_cnt_q + 32'h1;
	// Enable written while off; flags the first sample early
	wire ext_enter = wr_ctrl && wr_data[`CTRL_EXT_EN] &&
		!ctrl_q[`CTRL_EXT_EN];

	// Tracks min and max of every completed sample
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			last_q    <= {`PW{1'b0}};
			min_q     <= {`PW{1'b0}};
			max_q     <= {`PW{1'b0}};
			first_q   <= 1'b1;
			win_cnt_q <= 32'h0;
		end
		else
		begin
			if (avg_end)
			begin
				last_q <= power_in;
				if (ctrl_q[`CTRL_EXT_EN] && first_q)
				begin
					// First sample loads both extremes
					min_q <= power_in;
					max_q <= power_in;
				end
				else if (ctrl_q[`CTRL_EXT_EN])
				begin
					// Overwrite whichever extreme is passed
					if (power_in < min_q)
						min_q <= power_in;
					if (power_in > max_q)
						max_q <= power_in;
				end
			end
			if (ext_enter)
				// Entering the mode starts from scratch
				first_q <= 1'b1;
			else if (avg_end && ctrl_q[`CTRL_EXT_EN])
			begin
				win_cnt_q <= win_next;
				// Window full: next sample starts a new one
				first_q <= ctrl_q[`CTRL_EXT_REFR] &&
					(win_next >= window_q);
			end
		end
	end

	//--------------------------------------------------------------
	// Output pins
	//--------------------------------------------------------------
	// Begin pulse, range hold and trigger output from flops
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			trig_out   <= 1'b0;
			meas_begin <= 1'b0;
			range_hold <= 1'b0;
		end
		else
		begin
			meas_begin <= begin_ev;
			// Range frozen while a logging run is active
			range_hold <= busy && (func == `FUNC_LOG) && !single_q;
			if (glob == `GLOB_OFF)
				trig_out <= 1'b0;
			else if (tout == `TOUT_DONE)
				// Idles high, low pulse per finished sample
				trig_out <= !(avg_end ||
					(glob == `GLOB_FWD && trig_acc));
			else
				// Forwarding copies accepted triggers at once
				trig_out <= (glob == `GLOB_FWD && trig_acc) ||
					(tout == `TOUT_BEGIN && begin_ev);
		end
	end

	//--------------------------------------------------------------
	// Register port
	//--------------------------------------------------------------
	// Function, averaging, samples, loops and period frozen while running, shared by the run
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_q     <= 8'h0;
			trig_cfg_q <= 6'h0;
			avg_len_q  <= `RST_AVG;
			samples_q  <= `RST_SAMPLES;
			loops_q    <= `RST_LOOPS;
			period_q   <= `RST_PERIOD;
			window_q   <= `RST_WINDOW;
			buf_addr_q <= {`MEM_AW{1'b0}};
		end
		else if (wr_en)
		begin
			case (addr)
				`OFS_CTRL:
					ctrl_q <= {wr_data[7:4], 2'h0, busy ?
						ctrl_q[1:0] : wr_data[1:0]};
				`OFS_TRIG:     trig_cfg_q <= wr_data[5:0];
				`OFS_AVG:      if (!busy) avg_len_q <= wr_data;
				`OFS_SAMPLES:  if (!busy) samples_q <= wr_data;
				`OFS_LOOPS:    if (!busy) loops_q <= wr_data;
				`OFS_PERIOD:   if (!busy) period_q <= wr_data;
				`OFS_WINDOW:   window_q <= wr_data;
				`OFS_BUF_ADDR: buf_addr_q <= wr_data[`MEM_AW-1:0];
				default:       ctrl_q <= ctrl_q;
			endcase
		end
	end

	// Read data in the cycle after the strobe, zero otherwise
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			rd_data <= 32'h0;
		else if (!rd_en)
			rd_data <= 32'h0;
		else
		begin
			case (addr)
				`OFS_CTRL:     rd_data <= {24'h0, ctrl_q};
				`OFS_TRIG:     rd_data <= {26'h0, trig_cfg_q};
				`OFS_AVG:      rd_data <= avg_len_q;
				`OFS_SAMPLES:  rd_data <= samples_q;
				`OFS_LOOPS:    rd_data <= loops_q;
				`OFS_PERIOD:   rd_data <= period_q;
				`OFS_WINDOW:   rd_data <= window_q;
				`OFS_STATUS:
					rd_data <= {27'h0, buf_sel_q, range_hold,
						state_q, busy};
				// Delta replaces the reading in tracking mode
				`OFS_READING:
					rd_data <= {16'h0, ctrl_q[`CTRL_EXT_EN] ?
						max_q - min_q : last_q};
				`OFS_MIN:      rd_data <= {16'h0, min_q};
				`OFS_MAX:      rd_data <= {16'h0, max_q};
				`OFS_INDEX:    rd_data <= index_q;
				`OFS_BUF_ADDR: rd_data <= {11'h0, buf_addr_q};
				`OFS_BUF_DATA:
					rd_data <= {16'h0, buf_mem[buf_addr_q]};
				default:       rd_data <= 32'h0;
			endcase
		end
	end

endmodule // power_sample_sequencer
`default_nettype wire

// [bench/pss_partner.sv]
// External instrument model on the trigger lines
`timescale 1ns/1ps
`default_nettype none
module trig_partner
(
	input  wire logic sys_clk,
	input  wire logic fire,
	input  wire logic trig_out,
	output var  logic trig_in,
	output var  int   n_rise,
	output var  int   n_fall
);
	logic [1:0] left_q = 2'h0; // Pulse cycles still to send
	logic       last_q = 1'h0; // Trigger output one cycle ago
	initial
	begin
		trig_in = 1'h0;
		n_rise = 0;
		n_fall = 0;
	end
	// Active-high pulse, three cycles wide, and edge counts
	always @(posedge sys_clk)
	begin
		trig_in <= fire || left_q != 2'h0;
		left_q <= fire ? 2'h2 : left_q - {1'h0, left_q != 2'h0};
		last_q <= trig_out;
		if (trig_out && !last_q)
			n_rise <= n_rise + 1;
		if (!trig_out && last_q)
			n_fall <= n_fall + 1;
	end
endmodule // trig_partner
`default_nettype wire

// [bench/pss_assertions.sv]
// Port checker of the power sample sequencer
`timescale 1ns/1ps
`default_nettype none
`include "power_sample_sequencer_regs.vh"
module pss_checker
(
	input wire logic           sys_clk,
	input wire logic           resetn,
	input wire logic [7:0]     addr,
	input wire logic [31:0]    wr_data,
	input wire logic           wr_en,
	input wire logic           rd_en,
	input wire logic [31:0]    rd_data,
	input wire logic [`PW-1:0] power_in,
	input wire logic           trig_in,
	input wire logic           trig_out,
	input wire logic           meas_begin,
	input wire logic           range_hold
);
	logic [1:0]  func_q, glob_q, out_q; // Shadow settings
	logic [31:0] avg_q, samp_q, per_q;  // Shadow counts
	logic        one_q, tprev_q;        // Single loop, last output
	logic [2:0]  age_q;                 // Cycles since trigger setup
	logic [31:0] gap_q, nbeg_q;         // Begin spacing and count
	wire         wr_c = wr_en && addr == `OFS_CTRL;
	wire         wr_t = wr_en && addr == `OFS_TRIG;
	// Follow software writes and count interval begins
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			func_q <= 2'h0;
			glob_q <= 2'h0;
			out_q <= 2'h0;
			avg_q <= `RST_AVG;
			samp_q <= `RST_SAMPLES;
			per_q <= `RST_PERIOD;
			one_q <= 1'h1;
			age_q <= 3'h0;
			gap_q <= 32'h0;
			nbeg_q <= 32'h0;
			tprev_q <= 1'h0;
		end
		else
		begin
			if (wr_c)
				func_q <= wr_data[1:0];
			if (wr_t)
				glob_q <= wr_data[1:0];
			if (wr_t)
				out_q <= wr_data[5:4];
			if (wr_en && addr == `OFS_AVG)
				avg_q <= wr_data;
			if (wr_en && addr == `OFS_SAMPLES)
				samp_q <= wr_data;
			if (wr_en && addr == `OFS_PERIOD)
				per_q <= wr_data;
			if (wr_en && addr == `OFS_LOOPS)
				one_q <= wr_data == 32'h1;
			age_q <= wr_t ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
			gap_q <= meas_begin ? 32'h1 : gap_q + 32'h1;
			nbeg_q <= (wr_c && wr_data[2]) ? 32'h0
				: nbeg_q + {31'h0, meas_begin};
			tprev_q <= trig_out;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	a_fwd_pulse: assert property (
		glob_q == `GLOB_FWD && age_q == 3'h7 && out_q != `TOUT_DONE
		&& $rose(trig_in) |-> ##[2:6] trig_out)
		else $error("forwarded trigger missing");
	a_off_quiet: assert property (
		glob_q == `GLOB_OFF && age_q == 3'h7 |-> !trig_out)
		else $error("trigger output while disabled");
	a_done_width: assert property (
		glob_q == `GLOB_ON && out_q == `TOUT_DONE && age_q == 3'h7
		&& avg_q != 32'h1 && $fell(trig_out) |=> trig_out)
		else $error("done pulse not one cycle");
	a_begin_mark: assert property (
		glob_q == `GLOB_ON && out_q == `TOUT_BEGIN && age_q == 3'h7
		&& $rose(meas_begin) |-> ##[0:2] (trig_out || tprev_q))
		else $error("begin pulse missing");
	a_log_gap: assert property (
		meas_begin && func_q == `FUNC_LOG && one_q && nbeg_q != 32'h0
		|-> gap_q == avg_q)
		else $error("logging samples not back to back");
	a_log_count: assert property (
		$fell(range_hold) && func_q == `FUNC_LOG && one_q
		|=> nbeg_q == samp_q)
		else $error("logging run length wrong");
	a_stab_gap: assert property (
		meas_begin && func_q == `FUNC_STAB && nbeg_q != 32'h0
		|-> gap_q == per_q)
		else $error("stability period wrong");
	a_hold_log: assert property (
		range_hold |-> func_q == `FUNC_LOG)
		else $error("range held outside logging");
endmodule // pss_checker
bind power_sample_sequencer pss_checker chk_u (.sys_clk, .resetn, .addr,
	.wr_data, .wr_en, .rd_en, .rd_data, .power_in, .trig_in, .trig_out,
	.meas_begin, .range_hold);
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench of the power sample sequencer
`timescale 1ns/1ps
`default_nettype none
`include "power_sample_sequencer_regs.vh"
module tb_top;
	logic           sys_clk = 1'h0, resetn = 1'h0, fire = 1'h0;
	logic           wr_en = 1'h0, rd_en = 1'h0;
	logic [7:0]     addr = 8'h0;
	logic [31:0]    wr_data = 32'h0, rd_data, d, i0, i1;
	logic [`PW-1:0] power_in = 16'h0;
	logic           trig_in, trig_out, meas_begin, range_hold;
	int             n_errors = 0, comparisons = 0, cycles = 0;
	int             n_rise, n_fall, r0;
	power_sample_sequencer dut_u (.sys_clk, .resetn, .addr, .wr_data,
		.wr_en, .rd_en, .rd_data, .power_in, .trig_in, .trig_out,
		.meas_begin, .range_hold);
	trig_partner ext_u (.sys_clk, .fire, .trig_out, .trig_in, .n_rise,
		.n_fall);
	always #50 sys_clk = ~sys_clk;
	// Cut a hang short
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_errors++;
			stop_test();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		wr_en <= 1'h1;
		addr <= a;
		wr_data <= v;
		@(posedge sys_clk);
		wr_en <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		rd_en <= 1'h1;
		addr <= a;
		@(posedge sys_clk);
		rd_en <= 1'h0;
		@(negedge sys_clk);
		v = rd_data;
	endtask
	task automatic chk(input string s, input logic [31:0] e, g);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input string s);
		rd(a, d);
		chk(s, e, d);
	endtask
	// Ask the instrument for one trigger pulse
	task automatic pulse;
		@(posedge sys_clk);
		fire <= 1'h1;
		@(posedge sys_clk);
		fire <= 1'h0;
	endtask
	// Global modes, input functions, output sources
	task automatic t_trig;
		wr(`OFS_TRIG, 32'h02);
		cyc(8);
		r0 = n_rise;
		pulse();
		cyc(10);
		chk("forward", r0 + 1, n_rise);
		power_in <= 16'h55;
		wr(`OFS_TRIG, 32'h04);
		cyc(8);
		pulse();
		cyc(10);
		chk("off", r0 + 1, n_rise);
		rdc(`OFS_READING, 32'h0, "off reading");
		wr(`OFS_TRIG, 32'h05);
		cyc(8);
		pulse();
		cyc(12);
		rdc(`OFS_READING, 32'h55, "single");
		power_in <= 16'h66;
		wr(`OFS_TRIG, 32'h01);
		cyc(8);
		pulse();
		cyc(12);
		rdc(`OFS_READING, 32'h55, "ignore");
		wr(`OFS_CTRL, 32'h40);
		wr(`OFS_TRIG, 32'h05);
		pulse();
		cyc(5);
		power_in <= 16'h77;
		cyc(6);
		rdc(`OFS_READING, 32'h77, "falling edge");
		wr(`OFS_AVG, 32'h3);
		for (int k = 0; k < 2; k++)
		begin
			wr(`OFS_TRIG, k ? 32'h11 : 32'h21);
			cyc(8);
			r0 = k ? n_rise : n_fall;
			wr(`OFS_CTRL, 32'h4);
			cyc(20);
			wr(`OFS_CTRL, 32'h8);
			cyc(4);
			chk("out count", 32'h1, ((k ? n_rise : n_fall) - r0)
				inside {[6:8]});
		end
		wr(`OFS_TRIG, 32'h0);
	endtask
	// Continuous and refresh extremes
	task automatic t_ext;
		wr(`OFS_AVG, 32'h1);
		power_in <= 16'h1e;
		wr(`OFS_CTRL, 32'h14);
		cyc(3);
		power_in <= 16'h32;
		cyc(3);
		power_in <= 16'h0a;
		cyc(3);
		power_in <= 16'h28;
		cyc(3);
		wr(`OFS_CTRL, 32'h18);
		rdc(`OFS_MIN, 32'h0a, "min");
		rdc(`OFS_MAX, 32'h32, "max");
		rdc(`OFS_READING, 32'h28, "delta");
		wr(`OFS_WINDOW, 32'h3);
		power_in <= 16'h5a;
		wr(`OFS_CTRL, 32'h34);
		cyc(10);
		power_in <= 16'h14;
		cyc(10);
		wr(`OFS_CTRL, 32'h38);
		rdc(`OFS_MAX, 32'h14, "window max");
		rdc(`OFS_READING, 32'h0, "window delta");
	endtask
	// Logging with one, two and endless loops
	task automatic t_log;
		wr(`OFS_AVG, 32'h2);
		wr(`OFS_SAMPLES, 32'h4);
		rd(`OFS_INDEX, i0);
		power_in <= 16'h111;
		wr(`OFS_CTRL, 32'h5);
		cyc(3);
		@(negedge sys_clk);
		chk("hold", 32'h1, range_hold);
		cyc(12);
		@(negedge sys_clk);
		chk("hold end", 32'h0, range_hold);
		rdc(`OFS_INDEX, i0 + 1, "index");
		wr(`OFS_BUF_ADDR, 32'h3);
		rdc(`OFS_BUF_DATA, 32'h111, "buffer a");
		wr(`OFS_BUF_ADDR, 32'h100003);
		rd(`OFS_BUF_DATA, d);
		chk("b untouched", 32'h0, d === 32'h111);
		wr(`OFS_LOOPS, 32'h2);
		power_in <= 16'h222;
		wr(`OFS_CTRL, 32'h5);
		cyc(25);
		rdc(`OFS_INDEX, 32'h2, "index two");
		rdc(`OFS_BUF_DATA, 32'h222, "buffer b");
		wr(`OFS_LOOPS, 32'h0);
		wr(`OFS_CTRL, 32'h5);
		cyc(28);
		wr(`OFS_CTRL, 32'h9);
		rd(`OFS_STATUS, d);
		chk("stopped", 32'h0, d[0]);
		chk("alternate", 32'h1, d[4]);
		rd(`OFS_INDEX, i1);
		chk("endless", 32'h3, i1);
	endtask
	// Triggers start each loop, then a whole series
	task automatic t_each;
		wr(`OFS_LOOPS, 32'h2);
		wr(`OFS_TRIG, 32'h09);
		rdc(`OFS_INDEX, 32'h3, "index kept");
		wr(`OFS_CTRL, 32'h85);
		cyc(10);
		rd(`OFS_STATUS, d);
		chk("waiting", 32'h1, d[2:1]);
		pulse();
		cyc(20);
		rdc(`OFS_INDEX, 32'h1, "each one");
		pulse();
		cyc(20);
		rdc(`OFS_INDEX, 32'h2, "each two");
		wr(`OFS_CTRL, 32'h5);
		cyc(10);
		pulse();
		cyc(30);
		rdc(`OFS_INDEX, 32'h2, "series");
		wr(`OFS_TRIG, 32'h0);
	endtask
	// Stability with dwell, then without
	task automatic t_stab;
		wr(`OFS_PERIOD, 32'h8);
		wr(`OFS_SAMPLES, 32'h3);
		rdc(`OFS_INDEX, 32'h2, "index held");
		wr(`OFS_CTRL, 32'h6);
		cyc(20);
		rd(`OFS_STATUS, d);
		chk("final dwell", 32'h1, d[0]);
		cyc(8);
		rd(`OFS_STATUS, d);
		chk("stab end", 32'h0, d[0]);
		rdc(`OFS_INDEX, 32'h1, "stab index");
		wr(`OFS_PERIOD, 32'h2);
		wr(`OFS_CTRL, 32'h6);
		cyc(12);
		rd(`OFS_STATUS, d);
		chk("no dwell", 32'h0, d[0]);
	endtask
	task automatic stop_test;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		cyc(20);
		resetn <= 1'h1;
		t_trig();
		t_ext();
		t_log();
		t_each();
		t_stab();
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
